// ===== sfcu_defs.vh
// Constants for the supervisory flash call unit
`ifndef SFCU_DEFS_VH
`define SFCU_DEFS_VH

// Function codes carried in the accumulator
`define SFCU_FC_BOOT 8'h00
`define SFCU_FC_READ 8'h01
`define SFCU_FC_WRITE 8'h02
`define SFCU_FC_ERASE 8'h03
`define SFCU_FC_EALL 8'h05
`define SFCU_FC_TABLE 8'h06
`define SFCU_FC_SUM 8'h07

// Guard key value and stack offset
`define SFCU_FIRST_GUARD_KEY_VAL 8'h3A
`define SFCU_SP_OFFSET 8'h03

// Result codes
`define SFCU_RC_OK 8'h00
`define SFCU_RC_PROT 8'h01
`define SFCU_RC_SWRST 8'h02
`define SFCU_RC_FATAL 8'h03

// Parameter block in data RAM
`define SFCU_PB_FIRST_GUARD_KEY 8'hF8
`define SFCU_PB_SECOND_GUARD_KEY 8'hF9
`define SFCU_PB_LEN 4'h7
`define SFCU_PI_FIRST_GUARD_KEY 3'h0
`define SFCU_PI_SECOND_GUARD_KEY 3'h1
`define SFCU_PI_BLOCK 3'h2
`define SFCU_PI_PTR 3'h3
`define SFCU_PI_DIV 3'h4
`define SFCU_PI_DELAY 3'h6

// Block geometry
`define SFCU_BLOCK_LAST 7'h3F
`define SFCU_TABLE_SHIFT 3

// Hidden row layout
`define SFCU_CAL_BASE 14'h0040
`define SFCU_TABLE_BASE 14'h0080

// Flash commands
`define SFCU_CMD_NONE 3'h0
`define SFCU_CMD_PROG 3'h1
`define SFCU_CMD_ERASE_BLK 3'h2
`define SFCU_CMD_ERASE_USER 3'h3
`define SFCU_CMD_ZERO_USER 3'h4
`define SFCU_CMD_ERASE_PROT 3'h5
`define SFCU_CMD_ZERO_PROT 3'h6

// Protection levels
`define SFCU_PROT_NONE 2'h0
`define SFCU_PROT_READ 2'h1
`define SFCU_PROT_FULL 2'h3

// APB register map
`define SFCU_REG_STATUS 12'h000
`define SFCU_REG_CTRL 12'h004
`define SFCU_REG_SCALE 12'h008
`define SFCU_SCALE_RST 8'h04

`endif

// ===== sfcu_call_unit.v
// Supervisory flash call unit: dispatcher, flash sequencer and APB registers
//
// Function
// RQ1 - Call opcode from user code enters the function dispatcher.
// RQ2 - Caller loads a function code into the accumulator first.
// RQ3 - Undefined function code from user code halts the processor.
// RQ4 - Caller fills the parameter block at F8h..FFh before non-boot calls.
// RQ5 - Caller writes 3Ah into the first guard key before every call.
// RQ6 - Caller loads second key with stack pointer plus three.
// RQ7 - Wrong guard key halts the processor, except for boot reset.
// RQ8 - Caller reserves enough stack for the requested function.
// RQ9 - Result code goes to first key location: 00h, 01h, 02h, 03h.
// RQ10 - Integrity sum and table read return data there, not result codes.
// RQ11 - Full erase: per macro erase, zero, erase; then protection erase, zero.
// RQ12 - Accumulator 00h runs boot reset; hardware reset forces it.
// RQ13 - Bad key with nonzero function code never runs boot reset.
// RQ14 - Boot reset checks calibration data with a 16-bit sum first.
// RQ15 - Read-protected block: exit with code 01h, accumulator and second_guard_key zero.
// RQ16 - Allowed read copies 64 bytes to RAM at pointer, zeros result.
// RQ17 - Block write moves 64 RAM bytes to flash unless write protected.
// RQ18 - Caller keeps the block index within the flash size.
// RQ19 - Divider sets write pulse length; divider and delay suit CPU speed.
// RQ20 - Protection may refuse read, write and erase; levels fixed at programming.
// RQ21 - Block erase refused with code 01h when write protected.
// RQ22 - Function code, keys and parameters latched once at call entry.
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "sfcu_defs.vh"

module sfcu_call_unit #(
  parameter NUM_MACROS = 2,
  parameter CAL_LEN = 8
) (
  input wire clock,
  input wire arst_n,
  input wire callStrobe,
  input wire [7:0] accIn,
  input wire [7:0] spIn,
  output reg busy,
  output reg haltCpu,
  output reg accWe,
  output reg [7:0] accOut,
  output reg [7:0] ramAddr,
  output reg ramWe,
  output reg [7:0] ramWrData,
  input wire [7:0] ramRdData,
  output reg [13:0] flashAddr,
  output reg flashHidden,
  output reg [2:0] flashCmd,
  output reg [1:0] flashMacro,
  output reg flashStrobe,
  output reg [7:0] flashWrData,
  input wire [7:0] flashRdData,
  output wire [7:0] protBlock,
  input wire [1:0] protLevel,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr
);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_FETCH = 4'h1;
  localparam [3:0] S_CHECK = 4'h2;
  localparam [3:0] S_READ = 4'h3;
  localparam [3:0] S_WRITE = 4'h4;
  localparam [3:0] S_EALL = 4'h5;
  localparam [3:0] S_PULSE = 4'h6;
  localparam [3:0] S_DELAY = 4'h7;
  localparam [3:0] S_SUM = 4'h8;
  localparam [3:0] S_BOOT = 4'h9;
  localparam [3:0] S_FIN = 4'hA;
  localparam [3:0] S_HALTW = 4'hB;
  localparam [3:0] S_HALT = 4'hC;
  localparam [1:0] MACRO_TOP = NUM_MACROS - 1;

  reg [3:0] state;
  reg [3:0] retState;
  reg [7:0] fn;
  reg [7:0] spExpect;
  reg [7:0] par [0:6];
  reg [7:0] cnt;
  reg ph;
  reg [15:0] tmr;
  reg [15:0] sum;
  reg [15:0] sumRef;
  reg [7:0] result;
  reg resultOnly;
  reg bootPending;
  reg [7:0] lastRc;
  reg [1:0] eaPass;
  reg [1:0] eaMacro;
  reg [7:0] pulseScale;
  reg haltRelease;
  wire keyOk;
  wire apbWr;
  wire apbRd;
  wire apbHit;

  // Defined function codes; code 04h is a hole in the map
  function isDefined;
    input [7:0] code;
    begin
      isDefined = (code == `SFCU_FC_BOOT) || (code == `SFCU_FC_READ) ||
        (code == `SFCU_FC_WRITE) || (code == `SFCU_FC_ERASE) ||
        (code == `SFCU_FC_EALL) || (code == `SFCU_FC_TABLE) ||
        (code == `SFCU_FC_SUM);
    end
  endfunction

  // Refusal by protection level, for a read or a modifying access
  function refused;
    input [1:0] level;
    input forRead;
    begin
      if (forRead) begin
        refused = (level == `SFCU_PROT_READ) || (level == `SFCU_PROT_FULL);
      end else begin
        refused = (level == `SFCU_PROT_FULL);
      end
    end
  endfunction

  // Command sequence of full erase, indexed by pass and step
  function [2:0] eallCmd;
    input [1:0] pass;
    input [7:0] step;
    begin
      if (pass == 2'h0) begin
        eallCmd = (step[1:0] == 2'h1) ? `SFCU_CMD_ZERO_USER : `SFCU_CMD_ERASE_USER;
      end else begin
        eallCmd = (step[1:0] == 2'h1) ? `SFCU_CMD_ZERO_PROT : `SFCU_CMD_ERASE_PROT;
      end
    end
  endfunction

  // RQ7 key compare
  assign keyOk = (par[`SFCU_PI_FIRST_GUARD_KEY] == `SFCU_FIRST_GUARD_KEY_VAL) && (par[`SFCU_PI_SECOND_GUARD_KEY] == spExpect);
  assign protBlock = par[`SFCU_PI_BLOCK];

  // Zero-wait APB slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign apbHit = (paddr == `SFCU_REG_STATUS) || (paddr == `SFCU_REG_CTRL) ||
    (paddr == `SFCU_REG_SCALE);
  assign pslverr = psel & penable & ~apbHit;
  assign apbWr = psel & penable & pwrite & apbHit;
  assign apbRd = psel & ~penable & ~pwrite;

  // Register writes; halt release is a write-one pulse
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pulseScale <= `SFCU_SCALE_RST;
      haltRelease <= 1'b0;
    end else begin
      haltRelease <= apbWr && (paddr == `SFCU_REG_CTRL) && pwdata[0];
      if (apbWr && (paddr == `SFCU_REG_SCALE)) begin
        pulseScale <= pwdata[7:0];
      end
    end
  end

  // Read data captured in the setup cycle so it is stable in the access phase
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
    end else if (apbRd) begin
      case (paddr)
        `SFCU_REG_STATUS: prdata <= {6'h00, fn, lastRc, 4'h0, state, busy, haltCpu};
        `SFCU_REG_SCALE: prdata <= {24'h000000, pulseScale};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // Dispatcher and flash sequencer
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
      retState <= S_IDLE;
      fn <= 8'h00;
      spExpect <= 8'h00;
      par[0] <= 8'h00;
      par[1] <= 8'h00;
      par[2] <= 8'h00;
      par[3] <= 8'h00;
      par[4] <= 8'h00;
      par[5] <= 8'h00;
      par[6] <= 8'h00;
      cnt <= 8'h00;
      ph <= 1'b0;
      tmr <= 16'h0000;
      sum <= 16'h0000;
      sumRef <= 16'h0000;
      result <= 8'h00;
      resultOnly <= 1'b0;
      bootPending <= 1'b1;
      lastRc <= 8'h00;
      eaPass <= 2'h0;
      eaMacro <= 2'h0;
      busy <= 1'b1;
      haltCpu <= 1'b0;
      accWe <= 1'b0;
      accOut <= 8'h00;
      ramAddr <= 8'h00;
      ramWe <= 1'b0;
      ramWrData <= 8'h00;
      flashAddr <= 14'h0000;
      flashHidden <= 1'b0;
      flashCmd <= `SFCU_CMD_NONE;
      flashMacro <= 2'h0;
      flashStrobe <= 1'b0;
      flashWrData <= 8'h00;
    end else begin
      ramWe <= 1'b0;
      accWe <= 1'b0;
      case (state)
        S_IDLE: begin
          cnt <= 8'h00;
          ph <= 1'b0;
          sum <= 16'h0000;
          // RQ12 hardware reset forces boot
          if (bootPending) begin
            bootPending <= 1'b0;
            fn <= `SFCU_FC_BOOT;
            busy <= 1'b1;
            state <= S_BOOT;
          end else if (callStrobe) begin
            // RQ1 call entry; RQ22 latch code and stack once
            fn <= accIn;
            spExpect <= spIn + `SFCU_SP_OFFSET;
            busy <= 1'b1;
            state <= S_FETCH;
          end else begin
            busy <= 1'b0;
          end
        end
        S_FETCH: begin
          // RQ22 parameter block read once, address leads data by a cycle
          ramAddr <= `SFCU_PB_FIRST_GUARD_KEY + cnt;
          if (cnt != 8'h00) begin
            par[cnt[2:0] - 3'h1] <= ramRdData;
          end
          cnt <= cnt + 8'h01;
          if (cnt[3:0] == `SFCU_PB_LEN) begin
            cnt <= 8'h00;
            state <= S_CHECK;
          end
        end
        S_CHECK: begin
          result <= `SFCU_RC_OK;
          resultOnly <= 1'b0;
          eaPass <= 2'h0;
          eaMacro <= MACRO_TOP;
          if (!isDefined(fn)) begin
            // RQ3 undefined code halts
            state <= S_HALTW;
          end else if (fn == `SFCU_FC_BOOT) begin
            // RQ12 boot ignores keys and parameters
            state <= S_BOOT;
          end else if (!keyOk) begin
            // RQ7 RQ13 bad key halts, never boots
            state <= S_HALTW;
          end else if (fn == `SFCU_FC_READ) begin
            // RQ15 RQ20 read protection refusal
            if (refused(protLevel, 1'b1)) begin
              result <= `SFCU_RC_PROT;
              state <= S_FIN;
            end else begin
              state <= S_READ;
            end
          end else if ((fn == `SFCU_FC_WRITE) || (fn == `SFCU_FC_ERASE)) begin
            // RQ17 RQ21 write protection refusal
            if (refused(protLevel, 1'b0)) begin
              result <= `SFCU_RC_PROT;
              state <= S_FIN;
            end else if (fn == `SFCU_FC_WRITE) begin
              state <= S_WRITE;
            end else begin
              flashCmd <= `SFCU_CMD_ERASE_BLK;
              flashAddr <= {par[`SFCU_PI_BLOCK][7:0], 6'h00};
              flashHidden <= 1'b0;
              retState <= S_FIN;
              tmr <= 16'h0000;
              state <= S_PULSE;
            end
          end else if (fn == `SFCU_FC_EALL) begin
            state <= S_EALL;
          end else begin
            // RQ10 sum and table return data, no result code
            resultOnly <= 1'b1;
            state <= S_SUM;
          end
        end
        S_READ: begin
          // RQ16 copy 64 bytes flash to RAM at pointer
          if (!ph) begin
            flashAddr <= {par[`SFCU_PI_BLOCK][7:0], cnt[5:0]};
            flashHidden <= 1'b0;
            ph <= 1'b1;
          end else begin
            ramAddr <= par[`SFCU_PI_PTR] + cnt;
            ramWrData <= flashRdData;
            ramWe <= 1'b1;
            ph <= 1'b0;
            cnt <= cnt + 8'h01;
            if (cnt[6:0] == `SFCU_BLOCK_LAST) begin
              state <= S_FIN;
            end
          end
        end
        S_WRITE: begin
          // RQ17 fetch byte from RAM then program it
          if (cnt[6:0] == `SFCU_BLOCK_LAST + 7'h01) begin
            state <= S_FIN;
          end else if (!ph) begin
            ramAddr <= par[`SFCU_PI_PTR] + cnt;
            ph <= 1'b1;
          end else begin
            flashWrData <= ramRdData;
            flashAddr <= {par[`SFCU_PI_BLOCK][7:0], cnt[5:0]};
            flashHidden <= 1'b0;
            flashCmd <= `SFCU_CMD_PROG;
            ph <= 1'b0;
            cnt <= cnt + 8'h01;
            retState <= S_WRITE;
            tmr <= 16'h0000;
            state <= S_PULSE;
          end
        end
        S_EALL: begin
          // RQ11 user pass per macro, then protection pass per macro
          flashCmd <= eallCmd(eaPass, cnt);
          flashMacro <= eaMacro;
          retState <= S_EALL;
          tmr <= 16'h0000;
          if (eaPass == 2'h2) begin
            flashCmd <= `SFCU_CMD_NONE;
            state <= S_FIN;
          end else begin
            state <= S_PULSE;
            cnt <= cnt + 8'h01;
            if (cnt[1:0] == ((eaPass == 2'h0) ? 2'h2 : 2'h1)) begin
              cnt <= 8'h00;
              eaMacro <= eaMacro - 2'h1;
              if (eaMacro == 2'h0) begin
                eaMacro <= MACRO_TOP;
                eaPass <= eaPass + 2'h1;
              end
            end
          end
        end
        S_PULSE: begin
          // RQ19 pulse length scales with the divider parameter
          flashStrobe <= 1'b1;
          tmr <= tmr + 16'h0001;
          if (tmr == (({8'h00, par[`SFCU_PI_DIV]} + 16'h0001) * {8'h00, pulseScale})) begin
            flashStrobe <= 1'b0;
            tmr <= 16'h0000;
            state <= S_DELAY;
          end
        end
        S_DELAY: begin
          // RQ19 settle time from the delay parameter
          tmr <= tmr + 16'h0001;
          if (tmr[7:0] == par[`SFCU_PI_DELAY]) begin
            flashCmd <= `SFCU_CMD_NONE;
            state <= retState;
          end
        end
        S_SUM: begin
          // RQ10 sum of 64 bytes counting down from the indexed block's first byte, or one table byte
          if (!ph) begin
            flashHidden <= (fn == `SFCU_FC_TABLE);
            flashAddr <= (fn == `SFCU_FC_TABLE) ?
              (`SFCU_TABLE_BASE + {8'h00, par[`SFCU_PI_BLOCK][2:0], 3'h0}) :
              {par[`SFCU_PI_BLOCK][7:0], 6'h00} - {6'h00, cnt};
            ph <= 1'b1;
          end else begin
            ph <= 1'b0;
            if (fn == `SFCU_FC_TABLE) begin
              result <= flashRdData;
              state <= S_FIN;
            end else begin
              sum <= sum + {8'h00, flashRdData};
              result <= sum[7:0] + flashRdData;
              cnt <= cnt + 8'h01;
              if (cnt[6:0] == `SFCU_BLOCK_LAST) begin
                state <= S_FIN;
              end
            end
          end
        end
        S_BOOT: begin
          // RQ14 16-bit sum of calibration bytes, then stored reference
          if (!ph) begin
            flashHidden <= 1'b1;
            flashAddr <= `SFCU_CAL_BASE + {6'h00, cnt};
            ph <= 1'b1;
          end else begin
            ph <= 1'b0;
            cnt <= cnt + 8'h01;
            if (cnt < CAL_LEN) begin
              sum <= sum + {8'h00, flashRdData};
            end else if (cnt == CAL_LEN) begin
              sumRef[7:0] <= flashRdData;
            end else if ({sumRef[7:0], flashRdData} == sum) begin
              flashHidden <= 1'b0;
              busy <= 1'b0;
              state <= S_IDLE;
            end else begin
              state <= S_HALTW;
            end
          end
        end
        S_FIN: begin
          // RQ9 result code, then second_guard_key and accumulator cleared except for sum and table
          if (!ph) begin
            ramAddr <= `SFCU_PB_FIRST_GUARD_KEY;
            ramWrData <= result;
            ramWe <= 1'b1;
            if (!resultOnly) begin
              lastRc <= result;
            end
            ph <= 1'b1;
          end else begin
            ramAddr <= `SFCU_PB_SECOND_GUARD_KEY;
            ramWrData <= 8'h00;
            ramWe <= !resultOnly;
            accOut <= 8'h00;
            accWe <= !resultOnly;
            ph <= 1'b0;
            state <= S_IDLE;
          end
        end
        S_HALTW: begin
          // RQ9 fatal code written in the same cycle that halt is raised
          ramAddr <= `SFCU_PB_FIRST_GUARD_KEY;
          ramWrData <= `SFCU_RC_FATAL;
          ramWe <= 1'b1;
          lastRc <= `SFCU_RC_FATAL;
          haltCpu <= 1'b1;
          state <= S_HALT;
        end
        S_HALT: begin
          // Only software release or reset leaves the halt
          if (haltRelease) begin
            haltCpu <= 1'b0;
            busy <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== sfcu_call_unit_props.sv
// Port-level assertions for the supervisory flash call unit
`timescale 1ns/100ps
`default_nettype none
`include "sfcu_defs.vh"
module sfcu_call_unit_props (
  input wire clock,
  input wire arst_n,
  input wire callStrobe,
  input wire [7:0] accIn,
  input wire busy,
  input wire haltCpu,
  input wire accWe,
  input wire [7:0] accOut,
  input wire [7:0] ramAddr,
  input wire ramWe,
  input wire [7:0] ramWrData,
  input wire [13:0] flashAddr,
  input wire [2:0] flashCmd,
  input wire [1:0] flashMacro,
  input wire flashStrobe,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  a_call_starts: assert property (
    callStrobe && !busy && !haltCpu |=> busy) else $error("call not taken");
  a_fetch_start: assert property (
    callStrobe && !busy && !haltCpu && accIn != 8'h00 |=> ##1 ramAddr == `SFCU_PB_FIRST_GUARD_KEY)
    else $error("parameter fetch did not start");
  a_fatal_halt: assert property (
    ramWe && ramAddr == `SFCU_PB_FIRST_GUARD_KEY && ramWrData == `SFCU_RC_FATAL |-> ##[0:2] haltCpu)
    else $error("fatal code without halt");
  a_halt_holds: assert property (
    !(psel && penable && pwrite && paddr == `SFCU_REG_CTRL && pwdata[0]) ##1 (haltCpu
    && !(psel && penable && pwrite && paddr == `SFCU_REG_CTRL && pwdata[0])) |=> haltCpu)
    else $error("halt dropped");
  a_halted_quiet: assert property (
    haltCpu && $past(haltCpu, 3) |-> !ramWe && !accWe && !flashStrobe)
    else $error("activity while halted");
  a_finish_seq: assert property (
    accWe |-> accOut == 8'h00 && ramWe && ramAddr == `SFCU_PB_SECOND_GUARD_KEY && ramWrData == 8'h00
    ##1 !busy) else $error("bad finish sequence");
  a_rc_code: assert property (
    accWe |-> $past(ramWe) && $past(ramAddr) == `SFCU_PB_FIRST_GUARD_KEY
    && $past(ramWrData) <= `SFCU_RC_PROT) else $error("result code missing");
  a_cmd_held: assert property (
    flashStrobe && $past(flashStrobe) |-> $stable(flashCmd) && $stable(flashAddr)
    && $stable(flashMacro)) else $error("flash command moved in pulse");
  a_strobe_busy: assert property (
    flashStrobe |-> busy && !haltCpu) else $error("flash pulse outside a run");
endmodule
bind sfcu_call_unit sfcu_call_unit_props u_props (.clock, .arst_n, .callStrobe, .accIn,
  .busy, .haltCpu, .accWe, .accOut, .ramAddr, .ramWe, .ramWrData, .flashAddr, .flashCmd,
  .flashMacro, .flashStrobe, .psel, .penable, .pwrite, .paddr, .pwdata);
`default_nettype wire

// ===== sfcu_mem_model.sv
// Behavioural data RAM, flash array and protection table around the unit
`timescale 1ns/100ps
`default_nettype none
`include "sfcu_defs.vh"
module sfcu_mem_model (
  input wire logic clock,
  input wire logic [7:0] ramAddr,
  input wire logic ramWe,
  input wire logic [7:0] ramWrData,
  output logic [7:0] ramRdData,
  input wire logic [13:0] flashAddr,
  input wire logic flashHidden,
  input wire logic [2:0] flashCmd,
  input wire logic [1:0] flashMacro,
  input wire logic flashStrobe,
  input wire logic [7:0] flashWrData,
  output logic [7:0] flashRdData,
  input wire logic [7:0] protBlock,
  output logic [1:0] protLevel
);
  logic [7:0] ram [0:255];
  logic [7:0] flash [0:16383];
  logic [7:0] hidden [0:255];
  logic [1:0] prot [0:255];
  logic strobeQ;
  // Reads answer from the current address at once
  assign ramRdData = ram[ramAddr];
  assign flashRdData = flashHidden ? hidden[flashAddr[7:0]] : flash[flashAddr];
  assign protLevel = prot[protBlock];
  // Contents: pattern in user flash, calibration sum 021Ch in hidden row
  initial begin
    strobeQ = 1'b0;
    for (int i = 0; i < 16384; i++) flash[i] = i[7:0] ^ 8'h5A;
    for (int i = 0; i < 256; i++) begin
      ram[i] = 8'h00;
      hidden[i] = i[7:0];
      prot[i] = 2'h0;
    end
    hidden[8'h48] = 8'h02;
    hidden[8'h49] = 8'h1C;
    prot[1] = `SFCU_PROT_READ;
    prot[2] = `SFCU_PROT_FULL;
  end
  // Programming can only clear bits, as real flash does
  always @(posedge clock) begin
    strobeQ <= flashStrobe;
    if (ramWe) ram[ramAddr] <= ramWrData;
    if (flashStrobe && !strobeQ) begin
      case (flashCmd)
        `SFCU_CMD_PROG: flash[flashAddr] <= flash[flashAddr] & flashWrData;
        `SFCU_CMD_ERASE_BLK: for (int i = 0; i < 64; i++) flash[{flashAddr[13:6], i[5:0]}] <= 8'hFF;
        `SFCU_CMD_ERASE_USER: for (int i = 0; i < 8192; i++) flash[{flashMacro[0], i[12:0]}] <= 8'hFF;
        `SFCU_CMD_ZERO_USER: for (int i = 0; i < 8192; i++) flash[{flashMacro[0], i[12:0]}] <= 8'h00;
        `SFCU_CMD_ZERO_PROT: for (int i = 0; i < 128; i++) prot[{flashMacro[0], i[6:0]}] <= 2'h0;
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== tb_supervisory_flash_call_unit.sv
// Self-checking bench for the supervisory flash call unit
`timescale 1ns/100ps
`default_nettype none
`include "sfcu_defs.vh"
module tb_supervisory_flash_call_unit;
  logic clock, arst_n, callStrobe, busy, haltCpu, accWe, ramWe, flashHidden, flashStrobe;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] accIn, spIn, accOut, ramAddr, ramWrData, ramRdData, flashWrData, flashRdData;
  logic [7:0] protBlock, accSeen;
  logic [13:0] flashAddr;
  logic [2:0] flashCmd;
  logic [1:0] flashMacro, protLevel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  logic [4:0] cmdQ [$];
  int nMismatch, checked, cycles, hiCnt;
  sfcu_call_unit uut (.clock, .arst_n, .callStrobe, .accIn, .spIn, .busy, .haltCpu, .accWe,
    .accOut, .ramAddr, .ramWe, .ramWrData, .ramRdData, .flashAddr, .flashHidden, .flashCmd,
    .flashMacro, .flashStrobe, .flashWrData, .flashRdData, .protBlock, .protLevel, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  sfcu_mem_model mem (.clock, .ramAddr, .ramWe, .ramWrData, .ramRdData, .flashAddr,
    .flashHidden, .flashCmd, .flashMacro, .flashStrobe, .flashWrData, .flashRdData,
    .protBlock, .protLevel);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      nMismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      nMismatch++;
      $display("Error at %0t: cycles %h limit %h", $time, cycles, 20000);
      tally_and_finish();
    end
  end
  // pulse width and command log; values sampled before this edge lands
  always @(posedge clock) begin
    if (accWe === 1'b1) accSeen = accOut;
    if (flashStrobe === 1'b1) begin
      if (hiCnt == 0) cmdQ.push_back({flashCmd, flashMacro});
      hiCnt++;
    end else if (hiCnt != 0) begin
      cmp(hiCnt, 32'h2 * `SFCU_SCALE_RST);
      hiCnt = 0;
    end
  end
  // Runs until idle or halted; moves the pointer mid-run to catch late sampling
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(posedge clock);
    while (busy !== 1'b0 && haltCpu !== 1'b1) begin
      @(posedge clock);
      n++;
      if (n == 30) mem.ram[8'hFB] = 8'h80;
    end
    // Let RAM writes from the last edge land
    @(posedge clock);
  endtask
  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    wait_idle();
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // parameter block, then the call pulse
  task automatic sscall(input logic [7:0] code, input logic [7:0] blk, input logic [7:0] first_guard_key,
    input logic [7:0] k2off);
    accSeen = 8'hFF;
    mem.ram[8'hF8] = first_guard_key;
    mem.ram[8'hF9] = spIn + k2off;
    mem.ram[8'hFA] = blk;
    mem.ram[8'hFB] = 8'h10;
    mem.ram[8'hFC] = 8'h01;
    mem.ram[8'hFE] = 8'h02;
    accIn <= code;
    callStrobe <= 1'b1;
    @(posedge clock);
    callStrobe <= 1'b0;
    wait_idle();
  endtask
  task automatic t_boot();
    cmp(haltCpu, 1'b0);
    mem.hidden[8'h49] = 8'h1D;
    do_reset();
    cmp(haltCpu, 1'b1);
    cmp(mem.ram[8'hF8], `SFCU_RC_FATAL);
    mem.hidden[8'h49] = 8'h1C;
    do_reset();
    cmp(haltCpu, 1'b0);
    sscall(`SFCU_FC_BOOT, 8'h00, 8'h3B, 8'h00);
    cmp({haltCpu, mem.ram[8'hF8]}, 32'h3B);
    $display("Test boot done");
  endtask
  task automatic t_read();
    sscall(`SFCU_FC_READ, 8'h00, `SFCU_FIRST_GUARD_KEY_VAL, `SFCU_SP_OFFSET);
    for (int i = 0; i < 64; i++) cmp(mem.ram[8'h10 + i], i[7:0] ^ 8'h5A);
    cmp({mem.ram[8'hF8], mem.ram[8'hF9], accSeen}, 24'h0);
    mem.ram[8'h10] = 8'hC3;
    sscall(`SFCU_FC_READ, 8'h01, `SFCU_FIRST_GUARD_KEY_VAL, `SFCU_SP_OFFSET);
    cmp({mem.ram[8'hF8], mem.ram[8'hF9], accSeen, mem.ram[8'h10]}, 32'h010000C3);
    $display("Test read done");
  endtask
  task automatic t_erase_write();
    sscall(`SFCU_FC_ERASE, 8'h02, `SFCU_FIRST_GUARD_KEY_VAL, `SFCU_SP_OFFSET);
    cmp({mem.ram[8'hF8], mem.ram[8'hF9], accSeen}, 24'h010000);
    sscall(`SFCU_FC_WRITE, 8'h02, `SFCU_FIRST_GUARD_KEY_VAL, `SFCU_SP_OFFSET);
    cmp({mem.ram[8'hF8], mem.ram[8'hF9], accSeen}, 24'h010000);
    sscall(`SFCU_FC_ERASE, 8'h03, `SFCU_FIRST_GUARD_KEY_VAL, `SFCU_SP_OFFSET);
    cmp({mem.ram[8'hF8], mem.flash[14'h00C5]}, 16'h00FF);
    for (int i = 0; i < 64; i++) mem.ram[8'h10 + i] = i[7:0] ^ 8'hA5;
    sscall(`SFCU_FC_WRITE, 8'h03, `SFCU_FIRST_GUARD_KEY_VAL, `SFCU_SP_OFFSET);
    cmp(mem.ram[8'hF8], `SFCU_RC_OK);
    for (int i = 0; i < 64; i++) cmp(mem.flash[14'h00C0 + i], i[7:0] ^ 8'hA5);
    $display("Test erase and write done");
  endtask
  task automatic t_halt();
    logic [7:0] codes [4] = '{8'h01, 8'h03, 8'h04, 8'h08};
    logic [7:0] k1 [4] = '{8'h3B, 8'h3A, 8'h3A, 8'h3A};
    logic [7:0] k2 [4] = '{8'h03, 8'h04, 8'h03, 8'h03};
    for (int i = 0; i < 4; i++) begin
      sscall(codes[i], 8'h00, k1[i], k2[i]);
      cmp(haltCpu, 1'b1);
      cmp(mem.ram[8'hF8], `SFCU_RC_FATAL);
      apb(1'b0, `SFCU_REG_STATUS, 32'h0);
      cmp(rd[0], 1'b1);
      apb(1'b1, `SFCU_REG_CTRL, 32'h1);
      wait_idle();
      cmp(haltCpu, 1'b0);
    end
    apb(1'b0, 12'h00C, 32'h0);
    cmp(err, 1'b1);
    cmp(rd, 32'h0);
    apb(1'b0, `SFCU_REG_SCALE, 32'h0);
    cmp(rd, {24'h0, `SFCU_SCALE_RST});
    $display("Test halt done");
  endtask
  task automatic t_sum();
    logic [7:0] sum;
    sum = 8'h00;
    for (int i = 0; i < 64; i++) sum = sum + ((8'h00 - i[7:0]) ^ 8'h5A);
    sscall(`SFCU_FC_SUM, 8'h00, `SFCU_FIRST_GUARD_KEY_VAL, `SFCU_SP_OFFSET);
    cmp({mem.ram[8'hF8], mem.ram[8'hF9], accSeen}, {sum, spIn + 8'h03, 8'hFF});
    sscall(`SFCU_FC_TABLE, 8'h02, `SFCU_FIRST_GUARD_KEY_VAL, `SFCU_SP_OFFSET);
    cmp({mem.ram[8'hF8], mem.ram[8'hF9], accSeen}, {8'h90, spIn + 8'h03, 8'hFF});
    $display("Test sum done");
  endtask
  task automatic t_erase_all();
    logic [4:0] expQ [10] = '{5'h0D, 5'h11, 5'h0D, 5'h0C, 5'h10, 5'h0C, 5'h15, 5'h19, 5'h14,
      5'h18};
    cmdQ.delete();
    sscall(`SFCU_FC_EALL, 8'h00, `SFCU_FIRST_GUARD_KEY_VAL, `SFCU_SP_OFFSET);
    cmp(cmdQ.size(), 32'hA);
    for (int i = 0; i < 10 && i < cmdQ.size(); i++) cmp(cmdQ[i], expQ[i]);
    cmp({mem.ram[8'hF8], mem.flash[14'h0000], mem.flash[14'h2100]}, 24'h00FFFF);
    $display("Test full erase done");
  endtask
  initial begin
    arst_n = 1'b0;
    callStrobe = 1'b0;
    accIn = 8'h00;
    spIn = 8'hFE;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    nMismatch = 0;
    checked = 0;
    cycles = 0;
    hiCnt = 0;
    do_reset();
    t_boot();
    t_read();
    t_erase_write();
    t_halt();
    t_sum();
    t_erase_all();
    tally_and_finish();
  end
endmodule
`default_nettype wire
